//--- hdl/stc_monitor.v
// Overview of operation
// - Any safety input off blocks PWM drive to the power stage.
// - Monitoring output is on only when both safety inputs are off.
// - Both inputs on: PWM passes, monitor off, no alarm.
// - First on, second off: block PWM, monitor off, alarm 1c2.
// - First off, second on: block PWM, monitor off, alarm 1c1.
// - Both off: block PWM, monitor on, alarm 1c0.
// - Two independent channels, each alone blocks PWM; motor coasts.
// - Cutoff is armed from reset with no configuration step.
`timescale 1ns/1ps
`include "stc_defs.vh"

module stc_monitor #(
  parameter PWM_W = 6
) (
  input  wire                    sys_clk,
  input  wire                    sys_rst,
  input  wire                    safety_input_one,
  input  wire                    safety_input_two,
  input  wire [PWM_W-1:0]        pwm_in,
  output reg  [PWM_W-1:0]        pwm_out,
  output reg                     torque_cutoff_active,
  output reg                     cutoff_monitor_output,
  output reg  [`STC_ALARM_W-1:0] alarm_code,
  output reg                     alarm_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Channel states, one-hot
  localparam ST_W        = 4;
  localparam ST_RUN      = 4'h1;
  localparam ST_TWO_OFF  = 4'h2;
  localparam ST_ONE_OFF  = 4'h4;
  localparam ST_BOTH_OFF = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Both channels decode the same way
  function chan_off;
    input level;
    begin
      chan_off = (level != `STC_INPUT_ON);
    end
  endfunction

  // A change counts once stages two and three agree
  function stage_agree;
    input [2:0] stages;
    begin
      // Stage three is the oldest sample
      stage_agree = (stages[1] == stages[2]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers, one per channel, kept apart
  reg [2:0] sync_one;
  reg [2:0] sync_two;
  reg       level_one;
  reg       level_two;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_one <= 3'h0;
    end else begin
      sync_one <= {sync_one[1:0], safety_input_one};
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_two <= 3'h0;
    end else begin
      sync_two <= {sync_two[1:0], safety_input_two};
    end
  end

  // Reset to off: cutoff engaged until inputs prove on.
  // A one-cycle pulse never gets stages two and three to agree.
  // channel one armed from reset
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      level_one <= ~`STC_INPUT_ON;
    end else if (stage_agree(sync_one)) begin
      level_one <= sync_one[2];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      level_two <= ~`STC_INPUT_ON;
    end else if (stage_agree(sync_two)) begin
      level_two <= sync_two[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Evaluation
  wire one_off = chan_off(level_one);
  wire two_off = chan_off(level_two);

  wire block_one = one_off;
  wire block_two = two_off;
  wire next_cutoff = block_one | block_two;

  reg [ST_W-1:0] eval_state;

  always @* begin
    eval_state = ST_BOTH_OFF;
    case ({one_off, two_off})
      2'h0: begin
        eval_state = ST_RUN;
      end
      2'h1: begin
        eval_state = ST_TWO_OFF;
      end
      2'h2: begin
        eval_state = ST_ONE_OFF;
      end
      // Both off, and anything odd, falls to the safe state
      default: begin
        eval_state = ST_BOTH_OFF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered. The PWM gate has no enable, so nothing can
  // hold a stale pulse through a cutoff.
  // Outputs follow a pin change five edges later.

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pwm_out <= {PWM_W{1'h0}};
    end else if (next_cutoff) begin
      pwm_out <= {PWM_W{1'h0}};
    end else begin
      pwm_out <= pwm_in;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      torque_cutoff_active <= 1'h1;
    end else begin
      torque_cutoff_active <= next_cutoff;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cutoff_monitor_output <= 1'h0;
    end else begin
      case (eval_state)
        ST_RUN: begin
          cutoff_monitor_output <= 1'h0;
        end
        ST_TWO_OFF: begin
          cutoff_monitor_output <= 1'h0;
        end
        ST_ONE_OFF: begin
          cutoff_monitor_output <= 1'h0;
        end
        ST_BOTH_OFF: begin
          cutoff_monitor_output <= 1'h1;
        end
        default: begin
          cutoff_monitor_output <= 1'h0;
        end
      endcase
    end
  end

  // Alarms follow the inputs; not latched, as no clear path exists
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      alarm_code <= `STC_ALARM_NONE;
    end else begin
      case (eval_state)
        ST_RUN: begin
          alarm_code <= `STC_ALARM_NONE;
        end
        ST_TWO_OFF: begin
          alarm_code <= `STC_ALARM_CH_TWO;
        end
        ST_ONE_OFF: begin
          alarm_code <= `STC_ALARM_CH_ONE;
        end
        ST_BOTH_OFF: begin
          alarm_code <= `STC_ALARM_BOTH;
        end
        default: begin
          alarm_code <= `STC_ALARM_BOTH;
        end
      endcase
    end
  end

  // Valid while any alarm code is shown
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      alarm_valid <= 1'h0;
    end else begin
      alarm_valid <= next_cutoff;
    end
  end

endmodule // stc_monitor

//--- hdl/stc_defs.vh
`ifndef STC_DEFS_VH
`define STC_DEFS_VH

// Alarm codes as a 12-bit hex value: 1c0, 1c1, 1c2
`define STC_ALARM_W       12
`define STC_ALARM_NONE    12'h000
`define STC_ALARM_BOTH    12'h1c0
`define STC_ALARM_CH_ONE  12'h1c1
`define STC_ALARM_CH_TWO  12'h1c2

// Input level that means the safety channel is on
`define STC_INPUT_ON      1'h1

`endif

//--- testbench/stc_monitor_sva.sv
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_monitor_sva #(parameter PWM_W=6)(input wire sys_clk,sys_rst,
safety_input_one,safety_input_two,input wire [PWM_W-1:0] pwm_in,pwm_out,
input wire torque_cutoff_active,cutoff_monitor_output,alarm_valid,
input wire [11:0] alarm_code);
wire a=safety_input_one,b=safety_input_two,t=torque_cutoff_active;
wire m=cutoff_monitor_output,v=alarm_valid;
wire [11:0] c=alarm_code;
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
ok_a: assert property ((a&&b)[*7]|->!t&&!v) else $error("run");
two_a: assert property ((a&&!b)[*7]|->c==`STC_ALARM_CH_TWO&&!m)
  else $error("ch2");
one_a: assert property ((!a&&b)[*7]|->c==`STC_ALARM_CH_ONE&&!m)
  else $error("ch1");
off_a: assert property ((!a&&!b)[*7]|->m&&c==`STC_ALARM_BOTH)
  else $error("both");
block_a: assert property (t|->pwm_out=='0) else $error("pwm");
pass_a: assert property (!t|->pwm_out==$past(pwm_in)) else $error("pass");
mon_a: assert property (m|->t&&c==`STC_ALARM_BOTH) else $error("mon");
valid_a: assert property (v|->t&&c!=`STC_ALARM_NONE) else $error("val");
cover property (m);
cover property (c==`STC_ALARM_CH_ONE);
cover property (c==`STC_ALARM_CH_TWO);
endmodule // stc_monitor_sva
bind stc_monitor stc_monitor_sva #(.PWM_W(PWM_W)) chk (.*);

//--- testbench/stc_safety_ctrl.sv
`timescale 1ns/1ps
module stc_safety_ctrl(input wire sys_clk,input wire [1:0] cmd,
output reg safety_input_one=0,output reg safety_input_two=0);
// Levels change just after the edge, like a relay contact
always @(posedge sys_clk) #1 {safety_input_one,safety_input_two}<=cmd;
endmodule // stc_safety_ctrl

//--- testbench/test_stc_monitor.sv
`timescale 1ns/1ps
`include "stc_defs.vh"
module test_stc_monitor;
reg sys_clk=0,sys_rst=1;
reg [1:0] cmd=0;
reg [5:0] pwm_in=6'h2a;
wire safety_input_one,safety_input_two,torque_cutoff_active,alarm_valid;
wire cutoff_monitor_output;
wire [5:0] pwm_out;
wire [11:0] alarm_code;
integer err_total=0,checked=0;
always #50 sys_clk=~sys_clk;
stc_safety_ctrl ctl(.*);
stc_monitor uut(.*);
task chk(input [11:0] s,e,input string n);
checked=checked+1;
if(s!==e) begin
$display("[ERR] %s exp %h got %h",n,e,s);
err_total=err_total+1;
end
endtask
task complete_run;
$display("err %0d of %0d",err_total,checked);
if(err_total==0&&checked>0) $display("TB: PASS");
else $display("TB: FAIL");
$finish;
endtask
task step(input [1:0] k,input [11:0] x);
cmd=k;
pwm_in=~pwm_in;
repeat(8) @(posedge sys_clk);
#2 chk(alarm_code,x,"alarm");
chk(cutoff_monitor_output,k==0,"monitor");
chk(pwm_out,k==3?pwm_in:0,"pwm");
chk(torque_cutoff_active,k!=3,"cutoff");
chk(alarm_valid,k!=3,"valid");
endtask
task glitch;
cmd=1;
@(posedge sys_clk);
#2 cmd=3;
repeat(6) begin
@(posedge sys_clk);
#2 chk(alarm_valid,0,"glitch");
end
endtask
initial begin
#20000 err_total=err_total+1;
complete_run;
end
initial begin
repeat(3) @(posedge sys_clk);
#2 sys_rst=0;
step(0,`STC_ALARM_BOTH);
step(1,`STC_ALARM_CH_ONE);
step(2,`STC_ALARM_CH_TWO);
step(3,`STC_ALARM_NONE);
glitch;
step(0,`STC_ALARM_BOTH);
complete_run;
end
endmodule // test_stc_monitor
